// ===== tet_top.sv
// Purpose: Over-temperature pin timer, limit alert, fan override and critical pin drive.
// Assumes: AHB-Lite slave with one wait state per transfer; temperatures and fan state
//          come from logic on hclk; the pin itself is asynchronous.
// Notes:   Registers are 8 bits wide in the low byte of each word.
// Notes on behaviour
// - Timer runs only while pin asserted.
// - Timer accumulates across separate assertions.
// - Reading timer returns value then clears it.
// - Timer saturates at full scale until read.
// - Eight-bit timer; bit 0 set on first assertion.
// - Past two units, counts in unit steps.
// - Read during assertion restarts with bit 0 set.
// - Eight-bit assertion time limit register.
// - Timer above limit sets flag, raises alert.
// - Mask bit 5 blocks alert, not flag.
// - Limit zero alerts on first assertion.
// - Limit one alerts after two units.
// - Config three bit 1 enables pin monitoring.
// - Config three bit 2 forces full fan duty while pin asserted.
// - Drive pin low above critical limit.
// - Output condition re-evaluated once per cycle.
// - One critical limit register per channel.
// - Channel config bit 3 enables pin output.
// - Flags sticky until gone and status read.
// - Alert disabled until configured as alert.
// - Override only touches fans already running.
//
// The AHB-Lite register port was decided locally.
module tet_top #(
    parameter int unsigned UNIT_CYCLES = tet_pkg::UNIT_CYCLES,
    parameter int unsigned FANS        = 4,
    parameter int unsigned TW          = tet_pkg::TEMP_WIDTH
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    // Over-temperature pin, open drain
    input  wire logic          overtemp_pin_i,
    output logic               overtemp_pin_o,
    output logic               overtemp_pin_oe,
    // Measurement side
    input  wire logic          monitor_tick,
    input  wire logic [TW-1:0] temp_remote1,
    input  wire logic [TW-1:0] temp_local,
    input  wire logic [TW-1:0] temp_remote2,
    input  wire logic [FANS-1:0] fan_running,
    // Fan and alert
    output logic [FANS-1:0]    full_speed_override,
    output logic               alert_n
);
    import tet_pkg::*;

    localparam int unsigned PW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
    localparam logic [PW-1:0] UNIT_LAST = PW'(UNIT_CYCLES - 1);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tet_bus_type   bus_state;
    logic [7:0]    acc_index;
    logic          acc_write;
    logic          bus_accept;
    logic          acc_read;
    logic          acc_wr;
    logic [7:0]    wr_byte;
    logic [7:0]    next_rdata;

    logic [7:0]    chan_cfg [CHANNELS];
    logic [7:0]    crit_limit [CHANNELS];
    logic [7:0]    mask_two;
    logic [7:0]    config_three;
    logic [7:0]    assertion_time_limit;

    logic          pin_sync;
    logic          pin_asserted;
    logic [PW-1:0] prescaler;
    logic          unit_tick;
    logic [7:0]    elapsed_units;
    logic          seen_assert;
    logic [7:0]    assertion_time_counter;
    logic          counter_read;

    logic          limit_exceeded_flag;
    logic          critical_overtemp_flag;
    logic          limit_cond;
    logic          crit_cond;
    logic          status_read;
    logic [CHANNELS-1:0] chan_tripped;
    logic [TW-1:0] chan_temp [CHANNELS];

    assign chan_temp[0] = temp_remote1;
    assign chan_temp[1] = temp_local;
    assign chan_temp[2] = temp_remote2;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Every transfer gets one wait state so reads see the result of any
    // write just before them and read side effects happen exactly once.
    assign bus_accept = hsel && htrans[1] && hready && (bus_state == TET_BUS_IDLE);
    assign acc_read   = (bus_state == TET_BUS_ACCESS) && !acc_write;
    assign acc_wr     = (bus_state == TET_BUS_ACCESS) && acc_write;
    assign wr_byte    = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= TET_BUS_IDLE;
            acc_index <= 8'h00;
            acc_write <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            case (bus_state)
                TET_BUS_IDLE: begin
                    if (bus_accept) begin
                        bus_state <= TET_BUS_ACCESS;
                        acc_index <= haddr[9:2];
                        acc_write <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                TET_BUS_ACCESS: begin
                    bus_state <= TET_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    bus_state <= TET_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (acc_index)
            IDX_STATUS_TWO: begin
                next_rdata[STAT2_LIMIT_BIT] = limit_exceeded_flag;
                next_rdata[STAT2_CRIT_BIT]  = critical_overtemp_flag;
            end
            IDX_REMOTE1_CFG:    next_rdata = chan_cfg[0];
            IDX_LOCAL_CFG:      next_rdata = chan_cfg[1];
            IDX_REMOTE2_CFG:    next_rdata = chan_cfg[2];
            IDX_REMOTE1_CRIT:   next_rdata = crit_limit[0];
            IDX_LOCAL_CRIT:     next_rdata = crit_limit[1];
            IDX_REMOTE2_CRIT:   next_rdata = crit_limit[2];
            IDX_MASK_TWO:       next_rdata = mask_two;
            IDX_CONFIG_THREE:   next_rdata = config_three;
            IDX_ASSERT_COUNTER: next_rdata = assertion_time_counter;
            IDX_ASSERT_LIMIT:   next_rdata = assertion_time_limit;
            default:            next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc_read) begin
            hrdata <= {24'h00_0000, next_rdata};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                chan_cfg[i]   <= CHAN_CFG_RESET;
                crit_limit[i] <= CRIT_LIMIT_RESET;
            end
        end else if (acc_wr) begin
            case (acc_index)
                IDX_REMOTE1_CFG:  chan_cfg[0]   <= wr_byte;
                IDX_LOCAL_CFG:    chan_cfg[1]   <= wr_byte;
                IDX_REMOTE2_CFG:  chan_cfg[2]   <= wr_byte;
                IDX_REMOTE1_CRIT: crit_limit[0] <= wr_byte;
                IDX_LOCAL_CRIT:   crit_limit[1] <= wr_byte;
                IDX_REMOTE2_CRIT: crit_limit[2] <= wr_byte;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_two             <= MASK_TWO_RESET;
            config_three         <= CONFIG_THREE_RESET;
            assertion_time_limit <= ASSERT_LIMIT_RESET;
        end else if (acc_wr) begin
            case (acc_index)
                IDX_MASK_TWO:     mask_two             <= wr_byte;
                IDX_CONFIG_THREE: config_three         <= wr_byte;
                IDX_ASSERT_LIMIT: assertion_time_limit <= wr_byte;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin input and assertion timer
    // ------------------------------------------------------------------
    tet_sync #(
        .STAGES    (SYNC_STAGES),
        .RESET_VAL (1'b1)
    ) u_pin_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (overtemp_pin_i),
        .sync_out (pin_sync)
    );

    // Our own drive also pulls the pin low; that is counted like any other
    // assertion, as the wired pin cannot tell the two apart.
    assign pin_asserted = !pin_sync && config_three[CFG3_ENABLE_BIT];
    assign counter_read = acc_read && (acc_index == IDX_ASSERT_COUNTER);
    assign unit_tick    = pin_asserted && (prescaler == UNIT_LAST);

    // The prescaler keeps its partial count between assertions so short
    // assertions still add up to whole units.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler <= '0;
        end else if (counter_read) begin
            prescaler <= '0;
        end else if (pin_asserted) begin
            prescaler <= unit_tick ? '0 : prescaler + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed_units <= 8'h00;
        end else if (counter_read) begin
            elapsed_units <= 8'h00;
        end else if (unit_tick && (elapsed_units != COUNTER_FULL)) begin
            elapsed_units <= elapsed_units + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_assert <= 1'b0;
        end else if (counter_read) begin
            seen_assert <= pin_asserted;
        end else if (pin_asserted) begin
            seen_assert <= 1'b1;
        end
    end

    // Below two units only the first-assertion marker shows in bit 0.
    always_comb begin
        if (elapsed_units >= SCALE_START_UNITS) begin
            assertion_time_counter = elapsed_units;
        end else begin
            assertion_time_counter = {7'h00, seen_assert};
        end
    end

    // ------------------------------------------------------------------
    // Critical output drive
    // ------------------------------------------------------------------
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        tet_crit_chan #(
            .TW (TW)
        ) u_chan (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .monitor_tick (monitor_tick),
            .chan_enable  (chan_cfg[c][CHAN_OUT_EN_BIT]),
            .crit_limit   (crit_limit[c]),
            .temperature  (chan_temp[c]),
            .tripped      (chan_tripped[c])
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overtemp_pin_o  <= 1'b0;
            overtemp_pin_oe <= 1'b0;
        end else begin
            overtemp_pin_o  <= 1'b0;
            overtemp_pin_oe <= config_three[CFG3_ENABLE_BIT] && (|chan_tripped);
        end
    end

    // ------------------------------------------------------------------
    // Status flags and alert
    // ------------------------------------------------------------------
    assign limit_cond  = pin_asserted || seen_assert
                         ? (assertion_time_counter > assertion_time_limit) : 1'b0;
    assign crit_cond   = overtemp_pin_oe;
    assign status_read = acc_read && (acc_index == IDX_STATUS_TWO);

    // A set in the same cycle as a read-clear wins, so no event is lost.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limit_exceeded_flag <= 1'b0;
        end else if (limit_cond) begin
            limit_exceeded_flag <= 1'b1;
        end else if (status_read) begin
            limit_exceeded_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            critical_overtemp_flag <= 1'b0;
        end else if (crit_cond) begin
            critical_overtemp_flag <= 1'b1;
        end else if (status_read) begin
            critical_overtemp_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= !(config_three[CFG3_ALERT_BIT] &&
                        ((limit_exceeded_flag && !mask_two[MASK2_LIMIT_BIT]) ||
                         (critical_overtemp_flag && !mask_two[MASK2_CRIT_BIT])));
        end
    end

    // ------------------------------------------------------------------
    // Fan full speed override
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_speed_override <= '0;
        end else if (config_three[CFG3_FULL_SPEED_OVERRIDE_BIT] && pin_asserted) begin
            full_speed_override <= fan_running;
        end else begin
            full_speed_override <= '0;
        end
    end

endmodule

// ===== tet_pkg.sv
// Purpose: Shared constants for the thermal event timer block.
// Assumes: 25 MHz hclk; registers are one aligned 32-bit word each at four times their index.
// Notes:   Register indices are 8 bits; data is 8 bits in the low byte of each word.
package tet_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned UNIT_TIME_US   = 22760;
    localparam int unsigned UNIT_CYCLES    = (UNIT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES    = 2;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS_TWO      = 8'h42;
    localparam logic [7:0] IDX_REMOTE1_CFG     = 8'h5F;
    localparam logic [7:0] IDX_LOCAL_CFG       = 8'h60;
    localparam logic [7:0] IDX_REMOTE2_CFG     = 8'h61;
    localparam logic [7:0] IDX_REMOTE1_CRIT    = 8'h6A;
    localparam logic [7:0] IDX_LOCAL_CRIT      = 8'h6B;
    localparam logic [7:0] IDX_REMOTE2_CRIT    = 8'h6C;
    localparam logic [7:0] IDX_MASK_TWO        = 8'h75;
    localparam logic [7:0] IDX_CONFIG_THREE    = 8'h78;
    localparam logic [7:0] IDX_ASSERT_COUNTER  = 8'h79;
    localparam logic [7:0] IDX_ASSERT_LIMIT    = 8'h7A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CFG3_ALERT_BIT     = 0;
    localparam int unsigned CFG3_ENABLE_BIT    = 1;
    localparam int unsigned CFG3_FULL_SPEED_OVERRIDE_BIT     = 2;
    localparam int unsigned CHAN_OUT_EN_BIT    = 3;
    localparam int unsigned STAT2_CRIT_BIT     = 1;
    localparam int unsigned STAT2_LIMIT_BIT    = 5;
    localparam int unsigned MASK2_CRIT_BIT     = 1;
    localparam int unsigned MASK2_LIMIT_BIT    = 5;

    // ------------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CRIT_LIMIT_RESET    = 8'h64;
    localparam logic [7:0] CHAN_CFG_RESET      = 8'h00;
    localparam logic [7:0] MASK_TWO_RESET      = 8'h00;
    localparam logic [7:0] CONFIG_THREE_RESET  = 8'h00;
    localparam logic [7:0] ASSERT_LIMIT_RESET  = 8'h00;
    localparam logic [7:0] SCALE_START_UNITS   = 8'h02;
    localparam logic [7:0] COUNTER_FULL        = 8'hFF;
    localparam int unsigned CHANNELS           = 3;
    localparam int unsigned TEMP_WIDTH         = 10;

    typedef enum logic {
        TET_BUS_IDLE,
        TET_BUS_ACCESS
    } tet_bus_type;

endpackage

// ===== tet_sync.sv
// Purpose: Multi-stage synchroniser for levels entering the hclk domain.
// Assumes: Input is a slow level; no pulse shorter than a few clocks matters.
// Notes:   Only the last stage may be read by other logic.
module tet_sync #(
    parameter int unsigned STAGES    = tet_pkg::SYNC_STAGES,
    parameter logic        RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Level
    input  wire logic async_in,
    output wire logic sync_out
);
    import tet_pkg::*;

    logic [STAGES-1:0] chain;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain <= {STAGES{RESET_VAL}};
        end else begin
            chain <= {chain[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain[STAGES-1];

endmodule

// ===== tet_crit_chan.sv
// Purpose: Critical over-temperature compare for one temperature channel.
// Assumes: Temperature has two fraction bits (0.25 C per step), limit is whole degrees.
// Notes:   The result only moves on a monitoring-cycle tick.
module tet_crit_chan #(
    parameter int unsigned TW = tet_pkg::TEMP_WIDTH
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // Control
    input  wire logic          monitor_tick,
    input  wire logic          chan_enable,
    input  wire logic [7:0]    crit_limit,
    input  wire logic [TW-1:0] temperature,
    // Result
    output logic               tripped
);
    import tet_pkg::*;

    logic [TW-1:0] limit_scaled;

    // One quarter degree above the limit trips; at or below the limit releases.
    assign limit_scaled = TW'({crit_limit, 2'b00});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tripped <= 1'b0;
        end else if (monitor_tick) begin
            tripped <= chan_enable && (temperature > limit_scaled);
        end
    end

endmodule

// ===== tet_top_props.sv
// Purpose: Port properties of the thermal event timer top.
// Assumes: hready is tied to hreadyout; one clock domain.
// Notes:   Register contents are judged by the bench.
module tet_top_chk #(
    parameter int unsigned FANS = 4
) (
    // Clock and reset
    input wire logic            hclk,
    input wire logic            hresetn,
    // Bus
    input wire logic            hsel,
    input wire logic [1:0]      htrans,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic [31:0]     hrdata,
    input wire logic            hresp,
    // Pin, fans and alert
    input wire logic            overtemp_pin_i,
    input wire logic            overtemp_pin_o,
    input wire logic            overtemp_pin_oe,
    input wire logic            monitor_tick,
    input wire logic [FANS-1:0] fan_running,
    input wire logic [FANS-1:0] full_speed_override,
    input wire logic            alert_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_take;
        hsel && htrans[1] && hready && hreadyout;
    endsequence
    sequence s_wait_one;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_bus_wait: assert property (s_take |=> s_wait_one)
        else $error("data phase not one wait state");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_rdata_stand: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data moved outside a transfer");
    chk_rdata_byte: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_pin_open: assert property (overtemp_pin_o == 1'b0)
        else $error("pin driven high");
    chk_oe_tick: assert property ($changed(overtemp_pin_oe) |-> $past(monitor_tick, 2))
        else $error("pin drive moved without a tick");
    chk_full_speed_override_gate: assert property ((full_speed_override & ~$past(fan_running)) == '0)
        else $error("override on a stopped fan");
    chk_full_speed_override_idle: assert property (overtemp_pin_i [*4] |=> full_speed_override == '0)
        else $error("override while pin idle");
    chk_alert_release: assert property ($rose(alert_n) |-> $past(hreadyout, 2) == 1'b0)
        else $error("alert released without a register access");
endmodule

bind tet_top tet_top_chk #(.FANS(FANS)) u_chk (
    .hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hrdata, .hresp,
    .overtemp_pin_i, .overtemp_pin_o, .overtemp_pin_oe, .monitor_tick,
    .fan_running, .full_speed_override, .alert_n
);

// ===== tet_hot_src.sv
// Purpose: CPU hot output or trip sensor on the over-temperature pin.
// Assumes: Open drain; the pin has a pull-up, so a release reads high.
// Notes:   Registered, so the pin moves one edge after the request.
module tet_hot_src (
    // Clock
    input  wire logic hclk,
    // Request and drive
    input  wire logic hot_req,
    output logic      hot_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial hot_pull = 1'b0;
    always @(posedge hclk) begin
        hot_pull <= hot_req;
    end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the thermal event timer top.
// Assumes: UNIT_CYCLES shortened to 16; hready tied to hreadyout.
// Notes:   Loop pulse lengths sit a quarter unit past a boundary; the others sit a half unit off one, or on one.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tet_pkg::*;
    localparam int U = 16;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        hot_req = 1'b0, tick = 1'b0, mask5 = 1'b0, flag = 1'b0;
    logic        hreadyout, hresp, pin_o, pin_oe, alert_n, hot_pull;
    wire logic   pin_i;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [9:0]  t_r1 = '0, t_lo = '0, t_r2 = '0;
    logic [3:0]  fans = 4'hF, fso;
    logic [7:0]  cfg3 = 8'h00, w;
    int          mismatches = 0, n_compared = 0, acc = 0, lim = 0;
    int unsigned seed = 69503;
    logic [7:0]  ridx [12] = '{8'h5F, 8'h60, 8'h61, 8'h6A, 8'h6B, 8'h6C, 8'h75, 8'h78,
                               8'h79, 8'h7A, 8'h42, 8'h10};
    logic [7:0]  rval [12] = '{0, 0, 0, 8'h64, 8'h64, 8'h64, 0, 0, 0, 0, 0, 0};

    assign pin_i = (pin_oe ? pin_o : 1'b1) & ~hot_pull;

    tet_hot_src u_hot (.hclk(hclk), .hot_req(hot_req), .hot_pull(hot_pull));
    tet_top #(.UNIT_CYCLES(U)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .overtemp_pin_i(pin_i),
        .overtemp_pin_o(pin_o), .overtemp_pin_oe(pin_oe), .monitor_tick(tick),
        .temp_remote1(t_r1), .temp_local(t_lo), .temp_remote2(t_r2), .fan_running(fans),
        .full_speed_override(fso), .alert_n(alert_n)
    );

    // ------------------------------------------------------------------
    // Model and bus helpers
    // ------------------------------------------------------------------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_cnt(int a);
        if (a == 0) return 8'h00;
        if (a < 2 * U) return 8'h01;
        return (a / U > 255) ? 8'hFF : 8'(a / U);
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Caller stands just after a rising edge; returns at the edge that ends the data phase.
    task automatic xfer(logic wr, logic [7:0] idx, logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(string what, logic [7:0] idx, logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        check(what, {24'h0, e}, rd);
    endtask
    task automatic rcnt();
        rdc("counter", 8'h79, exp_cnt(acc));
        acc = 0;
    endtask
    task automatic pulse(int n);
        hot_req <= 1'b1;
        repeat (n) @(posedge hclk);
        check("override", cfg3[2] ? fans : 4'h0, fso);
        hot_req <= 1'b0;
        repeat (6) @(posedge hclk);
        if (cfg3[1]) acc += n;
        if (cfg3[1] && exp_cnt(acc) > lim) flag = 1'b1;
        check("alert", !(flag && cfg3[0] && !mask5), alert_n);
    endtask
    task automatic mtick(logic e);
        tick <= 1'b1;
        @(posedge hclk);
        tick <= 1'b0;
        repeat (2) @(posedge hclk);
        check("pin drive", e, pin_oe);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------------
    initial begin
        forever #20 hclk = ~hclk;
    end
    initial begin
        repeat (30000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_lo <= 10'(xs()) | 10'h200;
        t_r2 <= 10'(xs()) | 10'h200;
        foreach (ridx[i]) begin
            w = 8'(xs());
            rdc("reset value", ridx[i], rval[i]);
            xfer(1'b1, ridx[i], w);
            rdc("readback", ridx[i], (ridx[i] inside {8'h79, 8'h42, 8'h10}) ? rval[i] : w);
            xfer(1'b1, ridx[i], rval[i]);
        end
        pulse(3 * U);
        rcnt();
        cfg3 = 8'h07;
        lim = 1;
        xfer(1'b1, 8'h78, cfg3);
        xfer(1'b1, 8'h7A, 8'h01);
        fans <= 4'(xs());
        pulse(U / 2);
        rcnt();
        for (int k = 0; k < 3; k++) pulse(U / 4 + U * int'(1 + xs() % 2));
        rcnt();
        rdc("status", 8'h42, 8'h20);
        flag = 1'b0;
        @(posedge hclk);
        check("alert", 1'b1, alert_n);
        rdc("status", 8'h42, 8'h00);
        // Read during an assertion, masked, with a zero limit.
        mask5 = 1'b1;
        lim = 0;
        xfer(1'b1, 8'h75, 8'h20);
        xfer(1'b1, 8'h7A, 8'h00);
        hot_req <= 1'b1;
        repeat (2 * U + U / 2) @(posedge hclk);
        rdc("counter", 8'h79, exp_cnt(2 * U + U / 2));
        repeat (U / 2) @(posedge hclk);
        hot_req <= 1'b0;
        repeat (6) @(posedge hclk);
        acc = U / 2;
        rcnt();
        rdc("status", 8'h42, 8'h20);
        check("alert", 1'b1, alert_n);
        cfg3 = 8'h03;
        xfer(1'b1, 8'h78, cfg3);
        pulse(256 * U + U / 2);
        rcnt();
        // Critical drive from the first remote channel only.
        xfer(1'b1, 8'h5F, 8'h08);
        t_r1 <= 10'd401;
        mtick(1'b1);
        t_r1 <= 10'd400;
        repeat (5) @(posedge hclk);
        check("pin held", 1'b1, pin_oe);
        check("alert", 1'b0, alert_n);
        mtick(1'b0);
        xfer(1'b0, 8'h79, 8'h00);
        rdc("status", 8'h42, 8'h22);
        tally_and_finish();
    end
endmodule
